// File: core/beacon_flash_sequencer.sv
// Purpose: flash pattern sequencer for a solar beacon energy_manager
// Assumes: contact input already debounced, synchronous to clk_sys
// Notes:   one driver, two banks; bank enables are flip-flop outputs
`timescale 1ns/1ps

// How it works
// - eight selectable flash patterns
// - alternating 0.5 s, 60/min, default
// - unison 0.5 s, 60/min
// - alternating bursts of three 0.1 s
// - unison bursts of three 0.1 s
// - unison 0.25 s, 60/min
// - unison 0.1 s, 60/min
// - one driver switched between two banks
// - wigwag plus simultaneous mixes both phases
// - alternating with one fixture raises fault
// - fault shown on short, all-open, or bank b open while driven
// - good flash activation clears fault
// - cutoff blocks flashing and digital output
// - low charge reported, operation continues
// - report day/night flag and panel voltage
// - button closure starts timed flashing
// - normally open: flash while closed
// - normally closed: flash unless closed
// - duration 5..60 s in 1 s steps
// - duration to 1200 s in 60 s steps
// - duration also offers 3600 s
// - duration defaults to 20 s
module beacon_flash_sequencer (
  input  wire logic        clk_sys,        // 25 MHz system clock
  input  wire logic        rst,            // synchronous, active high
  input  wire logic [3:0]  reg_addr,       // register index
  input  wire logic [15:0] reg_wdata,      // write data
  input  wire logic        reg_wr,         // write strobe
  input  wire logic        reg_rd,         // read strobe
  output logic      [15:0] reg_rdata,      // read data, cycle after strobe
  input  wire logic        contact_closed, // contact_input_pos/neg shorted
  input  wire logic        bank_a_open,    // driver sees open on bank a
  input  wire logic        bank_b_open,    // driver sees open on bank b
  input  wire logic        led_short,      // driver sees a shorted fixture
  input  wire logic [1:0]  battery_state,  // from battery monitor
  input  wire logic        photo_night,    // photosensor says night
  input  wire logic [7:0]  solar_volts,    // panel voltage sample
  output logic             bank_a_on,      // bank a energised
  output logic             bank_b_on,      // bank b energised
  output logic             driver_on,      // shared led driver enabled
  output logic             digital_out,    // digital output signal
  output logic             led_fault       // fault indication visible
);

  // free-running timebase
  localparam int unsigned TICK_W = 15;
  localparam logic [TICK_W-1:0] TICK_LAST =
    TICK_W'(beacon_pkg::TICK_CYC - 1);
  localparam logic [9:0] MS_LAST = 10'(beacon_pkg::PERIOD_MS - 1);
  localparam logic [9:0] MS_LONG = 10'(beacon_pkg::PULSE_LONG_MS);
  localparam logic [9:0] MS_MID  = 10'(beacon_pkg::PULSE_MID_MS);
  localparam logic [9:0] MS_SHRT = 10'(beacon_pkg::PULSE_SHRT_MS);

  typedef enum logic [1:0] {ST_DARK, ST_FLASH} flash_state_e;

  logic [TICK_W-1:0] tick_q;     // cycles inside one millisecond
  logic [9:0]        ms_q;       // millisecond in the second
  logic [2:0]        pattern_q;  // selected pattern
  logic [1:0]        input_q;    // input_type_setting
  logic [11:0]       dur_q;      // flashing duration, seconds
  logic [11:0]       remain_q;   // seconds left in button mode
  logic              fault_q;    // latched led fault
  logic              dout_en_q;  // software wants digital output
  logic              contact_q;  // previous contact level
  flash_state_e      state_q;    // dark or flashing
  flash_state_e      state_d;
  logic              a_d;        // next bank a
  logic              b_d;        // next bank b
  logic              start_q;    // new activation awaiting its first lit cycle

  // duration check: only the documented values are accepted
  function automatic logic dur_legal(input logic [11:0] v);
    logic fine;
    logic coarse;
    fine   = (v >= 12'(beacon_pkg::DUR_MIN_S)) &&
             (v <= 12'(beacon_pkg::DUR_FINE_MAX));
    coarse = (v <= 12'(beacon_pkg::DUR_COARSE_MAX)) &&
             ((v % 12'(beacon_pkg::DUR_STEP_S)) == 12'h000) &&
             (v != 12'h000);
    return fine || coarse ||
           (v == 12'(beacon_pkg::DUR_HOUR_S));
  endfunction

  // millisecond window test used by the burst patterns
  function automatic logic in_win(input logic [9:0] t,
                                  input logic [9:0] s,
                                  input logic [9:0] len);
    return (t >= s) && (t < s + len);
  endfunction

  // decode
  // everything below is a plain combinational decode of counters, inputs and strobes
  wire ms_wrap   = (tick_q == TICK_LAST);
  wire sec_wrap  = ms_wrap && (ms_q == MS_LAST);
  wire cutoff    = (battery_state == beacon_pkg::BATT_CUTOFF);
  wire press     = contact_closed && !contact_q;
  wire wr_pat    = reg_wr && (reg_addr == beacon_pkg::REG_PATTERN);
  wire wr_in     = reg_wr && (reg_addr == beacon_pkg::REG_INPUT);
  wire wr_dur    = reg_wr && (reg_addr == beacon_pkg::REG_DURATION) &&
                   dur_legal(reg_wdata[11:0]);
  wire wr_dout   = reg_wr && (reg_addr == beacon_pkg::REG_DOUT);
  // three quick pulses: 0.1 s on, 0.1 s off, starting at 0, 200, 400 ms
  wire burst     = in_win(ms_q, 10'h000, MS_SHRT) ||
                   in_win(ms_q, 10'h0c8, MS_SHRT) ||
                   in_win(ms_q, 10'h190, MS_SHRT);
  wire first_half = (ms_q < MS_LONG);

  // timebase: counters never stop so every edge is on the 1 s grid
  always_ff @(posedge clk_sys) begin
    if (rst || ms_wrap) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || sec_wrap) begin
      ms_q <= '0;
    end else if (ms_wrap) begin
      ms_q <= ms_q + 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pattern_q <= beacon_pkg::PAT_RESET;
      input_q   <= beacon_pkg::IN_RESET;
      dur_q     <= beacon_pkg::DUR_RESET_S;
      dout_en_q <= 1'b0;
    end else begin
      if (wr_pat) pattern_q <= reg_wdata[2:0];
      if (wr_in && reg_wdata[1:0] != 2'h3) input_q <= reg_wdata[1:0];
      if (wr_dur) dur_q <= reg_wdata[11:0];
      if (wr_dout) dout_en_q <= reg_wdata[0];
    end
  end

  // activation state: decides whether we should be flashing at all
  // the mode decode is level based except in button mode
  always_comb begin
    state_d = state_q;
    case (input_q)
      beacon_pkg::IN_NORM_OPEN:
        state_d = contact_closed ? ST_FLASH : ST_DARK;
      beacon_pkg::IN_NORM_CLOSED:
        state_d = contact_closed ? ST_DARK : ST_FLASH;
      default: begin
        if (press) begin
          state_d = ST_FLASH;
        end else if (state_q == ST_FLASH && remain_q == 12'h000) begin
          state_d = ST_DARK;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q   <= ST_DARK;
      contact_q <= 1'b0;
      remain_q  <= '0;
      start_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      contact_q <= contact_closed;
      // banks light one edge after the state, so the clear check must
      // wait for them; judging the dark cycle would never clear a fault
      if (state_d != ST_FLASH) begin
        start_q <= 1'b0;                     // dark again, nothing pending
      end else if (state_q != ST_FLASH) begin
        start_q <= 1'b1;                     // new activation begins
      end else if (bank_a_on || bank_b_on) begin
        start_q <= 1'b0;                     // first lit cycle was judged
      end
      if (press && input_q == beacon_pkg::IN_BUTTON) begin
        remain_q <= dur_q;
      end else if (sec_wrap && remain_q != 12'h000) begin
        remain_q <= remain_q - 1'b1;
      end
    end
  end

  // bank pattern generation
  // every shape is a window on the free ms counter, so a pattern
  // change takes effect mid-second without any resynchronisation
  always_comb begin
    a_d = 1'b0;
    b_d = 1'b0;
    case (pattern_q)
      beacon_pkg::PAT_ALT: begin
        a_d = first_half;
        b_d = !first_half;
      end
      beacon_pkg::PAT_UNI: begin
        a_d = first_half;
        b_d = first_half;
      end
      beacon_pkg::PAT_CUSTOM: begin
        // rapid alternating beacon, 0.1 s slots, alternating across
        a_d = burst;
        b_d = in_win(ms_q, 10'h064, MS_SHRT) ||
              in_win(ms_q, 10'h12c, MS_SHRT) ||
              in_win(ms_q, 10'h1f4, MS_SHRT);
      end
      beacon_pkg::PAT_WWS: begin
        // bank a bursts alone in first half, both lit from 500 to 600 ms, then dark
        a_d = burst || in_win(ms_q, MS_LONG, MS_SHRT);
        b_d = (!first_half && !burst) ||
              in_win(ms_q, MS_LONG, MS_SHRT);
        b_d = b_d && (ms_q < 10'h258);
        a_d = a_d && (ms_q < 10'h258);
      end
      beacon_pkg::PAT_ALT_QUICK: begin
        a_d = burst;
        b_d = in_win(ms_q, MS_LONG, MS_SHRT) ||
              in_win(ms_q, 10'h2bc, MS_SHRT) ||
              in_win(ms_q, 10'h384, MS_SHRT);
      end
      beacon_pkg::PAT_UNI_QUICK: begin
        a_d = burst;
        b_d = burst;
      end
      beacon_pkg::PAT_UNI_MID: begin
        a_d = (ms_q < MS_MID);
        b_d = (ms_q < MS_MID);
      end
      default: begin
        a_d = (ms_q < MS_SHRT);
        b_d = (ms_q < MS_SHRT);
      end
    endcase
  end

  // outputs: cutoff wins over any activation; low charge does not gate
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bank_a_on   <= 1'b0;
      bank_b_on   <= 1'b0;
      digital_out <= 1'b0;
    end else begin
      bank_a_on   <= a_d && (state_q == ST_FLASH) && !cutoff;
      bank_b_on   <= b_d && (state_q == ST_FLASH) && !cutoff;
      digital_out <= dout_en_q && (state_q == ST_FLASH) && !cutoff;
    end
  end

  assign driver_on = bank_a_on || bank_b_on;

  // fault: short anywhere, every energised bank open, or bank b open while driven
  // open sense only means something while that bank is driven,
  // hence every open-sense term is qualified by its bank enable
  wire any_on   = bank_a_on || bank_b_on;
  wire all_open = (!bank_a_on || bank_a_open) &&
                  (!bank_b_on || bank_b_open);
  wire bad_now  = any_on && (led_short || all_open ||
                  (bank_b_on && bank_b_open));
  wire good_now = any_on && !led_short && !bad_now;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fault_q <= 1'b0;
    end else if (bad_now) begin
      fault_q <= 1'b1;
    end else if (good_now && start_q) begin
      fault_q <= 1'b0;
    end
  end

  assign led_fault = fault_q;

  // register read path, data the cycle after the strobe
  // unmapped indices read as zero
  wire [15:0] status_w = {11'h000, (state_q == ST_FLASH), battery_state,
                          photo_night, fault_q};
  wire [15:0] rd_mux =
    (reg_addr == beacon_pkg::REG_PATTERN)  ? {13'h0000, pattern_q} :
    (reg_addr == beacon_pkg::REG_INPUT)    ? {14'h0000, input_q} :
    (reg_addr == beacon_pkg::REG_DURATION) ? {4'h0, dur_q} :
    (reg_addr == beacon_pkg::REG_STATUS)   ? status_w :
    (reg_addr == beacon_pkg::REG_SOLAR)    ? {8'h00, solar_volts} :
    (reg_addr == beacon_pkg::REG_DOUT)     ? {15'h0000, dout_en_q} :
    16'h0000;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // checks
  a_cutoff_dark: assert property (@(posedge clk_sys) disable iff (rst)
    $past(cutoff) |-> !bank_a_on && !bank_b_on && !digital_out)
    else $error("banks lit during cutoff");
  a_alt_exclusive: assert property (@(posedge clk_sys) disable iff (rst)
    (pattern_q == beacon_pkg::PAT_ALT) && $stable(pattern_q)
      |-> !(bank_a_on && bank_b_on))
    else $error("alternating banks overlap");
  a_uni_together: assert property (@(posedge clk_sys) disable iff (rst)
    $past(pattern_q == beacon_pkg::PAT_UNI) |-> bank_a_on == bank_b_on)
    else $error("unison banks differ");
  a_no_open_dark: assert property (@(posedge clk_sys) disable iff (rst)
    (input_q == beacon_pkg::IN_NORM_OPEN) && !contact_closed ##1
      (input_q == beacon_pkg::IN_NORM_OPEN) |=> !bank_a_on && !bank_b_on)
    else $error("normally open input flashing while open");
  a_button_start: assert property (@(posedge clk_sys) disable iff (rst)
    press && input_q == beacon_pkg::IN_BUTTON |=> state_q == ST_FLASH)
    else $error("button press did not start flashing");
  a_short_fault: assert property (@(posedge clk_sys) disable iff (rst)
    any_on && led_short |=> led_fault)
    else $error("short not reported");
  a_dur_legal: assert property (@(posedge clk_sys) disable iff (rst)
    dur_legal(dur_q))
    else $error("illegal duration stored");
  a_sec_period: assert property (@(posedge clk_sys) disable iff (rst)
    sec_wrap |=> ms_q == 10'h000)
    else $error("second counter did not wrap");
  // checks that short runs also reach
  // ms counter never leaves its one-second range
  a_ms_bound: assert property (@(posedge clk_sys) disable iff (rst)
    ms_q <= MS_LAST)
    else $error("ms counter out of range");
  // digital output only follows a flashing, powered cycle
  a_dout_gate: assert property (@(posedge clk_sys) disable iff (rst)
    digital_out |-> $past(state_q == ST_FLASH) && !$past(cutoff))
    else $error("digital output without flashing");
  // the shared driver is idle during cutoff too
  a_cut_no_drive: assert property (@(posedge clk_sys) disable iff (rst)
    $past(cutoff) |-> !driver_on)
    else $error("driver on during cutoff");
  // low charge keeps the digital output alive
  a_low_runs: assert property (@(posedge clk_sys) disable iff (rst)
    battery_state == beacon_pkg::BATT_LOW && state_q == ST_FLASH &&
      dout_en_q |=> digital_out)
    else $error("low charge stopped the output");
  // normally closed flashes while the contact is open
  a_nc_flash: assert property (@(posedge clk_sys) disable iff (rst)
    input_q == beacon_pkg::IN_NORM_CLOSED && !contact_closed
      |=> state_q == ST_FLASH)
    else $error("normally closed input not flashing");
  // quick unison keeps both banks in step
  a_quick_same: assert property (@(posedge clk_sys) disable iff (rst)
    $past(pattern_q == beacon_pkg::PAT_UNI_QUICK) |-> bank_a_on == bank_b_on)
    else $error("quick unison banks differ");
  // alternating flashing lights exactly one bank at a time
  a_alt_one_bank: assert property (@(posedge clk_sys) disable iff (rst)
    $past(pattern_q == beacon_pkg::PAT_ALT) && $past(state_q == ST_FLASH) &&
      !$past(cutoff) |-> bank_a_on != bank_b_on)
    else $error("alternating not one bank");
  // a clean first lit cycle of an activation clears the fault
  a_fault_clear: assert property (@(posedge clk_sys) disable iff (rst)
    start_q && good_now |=> !led_fault)
    else $error("good activation left fault set");
  // a press reloads the full duration
  a_remain_load: assert property (@(posedge clk_sys) disable iff (rst)
    press && input_q == beacon_pkg::IN_BUTTON |=> remain_q == $past(dur_q))
    else $error("press did not reload timer");
endmodule

// File: core/beacon_pkg.sv
// Purpose: shared constants for the beacon flash sequencer
// Assumes: 25 MHz system clock
// Notes:   pattern, input mode and battery encodings live here
package beacon_pkg;
  // clock rate and timing
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned PERIOD_MS     = 1000;  // one repetition, ms
  localparam int unsigned PULSE_LONG_MS = 500;
  localparam int unsigned PULSE_MID_MS  = 250;
  localparam int unsigned PULSE_SHRT_MS = 100;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000;  // cycles per ms
  // duration limits, seconds
  localparam int unsigned DUR_MIN_S     = 5;
  localparam int unsigned DUR_FINE_MAX  = 60;
  localparam int unsigned DUR_COARSE_MAX= 1200;
  localparam int unsigned DUR_STEP_S    = 60;
  localparam int unsigned DUR_HOUR_S    = 3600;
  localparam logic [11:0] DUR_RESET_S   = 12'h014;  // 20 s
  // flash pattern codes
  localparam logic [2:0] PAT_ALT       = 3'h0;  // alternating 0.5 s
  localparam logic [2:0] PAT_UNI       = 3'h1;  // unison 0.5 s
  localparam logic [2:0] PAT_CUSTOM    = 3'h2;  // custom rapid beacon
  localparam logic [2:0] PAT_WWS       = 3'h3;  // wigwag_plus_simultaneous
  localparam logic [2:0] PAT_ALT_QUICK = 3'h4;
  localparam logic [2:0] PAT_UNI_QUICK = 3'h5;
  localparam logic [2:0] PAT_UNI_MID   = 3'h6;  // unison 0.25 s
  localparam logic [2:0] PAT_UNI_SHORT = 3'h7;  // unison 0.1 s
  localparam logic [2:0] PAT_RESET     = PAT_ALT;
  // input_type_setting codes
  localparam logic [1:0] IN_BUTTON     = 2'h0;
  localparam logic [1:0] IN_NORM_OPEN  = 2'h1;
  localparam logic [1:0] IN_NORM_CLOSED= 2'h2;
  localparam logic [1:0] IN_RESET      = IN_BUTTON;
  // battery state codes
  localparam logic [1:0] BATT_GOOD     = 2'h0;
  localparam logic [1:0] BATT_LOW      = 2'h1;
  localparam logic [1:0] BATT_CUTOFF   = 2'h2;  // low_voltage_cutoff
  // register map
  localparam logic [3:0] REG_PATTERN   = 4'h0;
  localparam logic [3:0] REG_INPUT     = 4'h1;
  localparam logic [3:0] REG_DURATION  = 4'h2;
  localparam logic [3:0] REG_STATUS    = 4'h3;
  localparam logic [3:0] REG_SOLAR     = 4'h4;
  localparam logic [3:0] REG_DOUT      = 4'h5;
  // status field positions
  localparam int unsigned ST_FAULT_BIT = 0;
  localparam int unsigned ST_NIGHT_BIT = 1;
  localparam int unsigned ST_BATT_LSB  = 2;
  localparam int unsigned ST_FLASH_BIT = 4;
endpackage

// File: test/contact_switch.sv
// Purpose: model of the contact that closes across the input pair
// Assumes: contact is already debounced when it reaches the block
// Notes:   slow mode lags the request by five cycles, like a relay
`timescale 1ns/1ps
module contact_switch (
  input  wire logic clk_sys,        // bench clock
  input  wire logic close_req,      // wanted contact state
  input  wire logic slow,           // answer late
  output logic      contact_closed  // terminals shorted
);
  logic [3:0] lag_q = 4'h0;  // request history for slow mode
  initial contact_closed = 1'b0;
  // installer picks the mode; contact only shorts or opens
  always_ff @(posedge clk_sys) begin
    lag_q <= {lag_q[2:0], close_req};
    contact_closed <= slow ? lag_q[3] : close_req;
  end
endmodule

// File: test/testbench.sv
// Purpose: self-checking bench for the beacon flash sequencer
// Assumes: ms grid starts at zero on reset; run stays in first 100 ms
// Notes:   reads and output looks are queued and checked by a monitor
`timescale 1ns/1ps
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        contact_closed;
  logic        bank_a_open = 1'b0;
  logic        bank_b_open = 1'b0;
  logic        led_short = 1'b0;
  logic [1:0]  battery_state = 2'h0;
  logic        photo_night = 1'b0;
  logic [7:0]  solar_volts = 8'h00;
  logic        bank_a_on, bank_b_on, driver_on, digital_out, led_fault;
  logic        close_req = 1'b0;  // wanted contact state
  logic        slow = 1'b0;       // partner answers late
  logic        look = 1'b0;       // output sample request
  logic        rd_seen = 1'b0;    // read data due now
  logic [31:0] lfsr = 32'hf5c7;
  logic [15:0] rd_q[$];           // expected read data
  logic [4:0]  out_q[$];          // expected a, b, driver, dout, fault
  logic [11:0] dur_v[8] = '{12'h005, 12'h03c, 12'h004, 12'h03d,
                            12'h078, 12'h4b0, 12'h4ec, 12'he10};
  logic        dur_ok[8] = '{1, 1, 0, 0, 1, 1, 0, 1};
  logic [1:0]  pat_ab[8] = '{2'b10, 2'b11, 2'b00, 2'b00,
                             2'b10, 2'b11, 2'b11, 2'b11};
  logic [15:0] dur_exp;
  int          fails = 0;
  int          comparisons = 0;
  int          i;
  always #20 clk_sys = ~clk_sys;
  beacon_flash_sequencer i_beacon_flash_sequencer (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .contact_closed(contact_closed),
    .bank_a_open(bank_a_open), .bank_b_open(bank_b_open),
    .led_short(led_short), .battery_state(battery_state),
    .photo_night(photo_night), .solar_volts(solar_volts),
    .bank_a_on(bank_a_on), .bank_b_on(bank_b_on), .driver_on(driver_on),
    .digital_out(digital_out), .led_fault(led_fault));
  contact_switch i_contact_switch (.clk_sys(clk_sys),
    .close_req(close_req), .slow(slow), .contact_closed(contact_closed));
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_data(input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("FAIL reg_rdata expected %h seen %h", e, g);
    end
  endtask
  task automatic cmp_outs(input logic [4:0] e, input logic [4:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("FAIL outputs expected %b seen %b", e, g);
    end
  endtask
  task automatic close_out;
    $display("counts: %0d comparisons, %0d fails", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // monitor: oldest note meets each result as it appears
  always @(posedge clk_sys) begin
    if (rd_seen && rd_q.size() > 0) cmp_data(rd_q.pop_front(), reg_rdata);
    if (look && out_q.size() > 0) cmp_outs(out_q.pop_front(),
      {bank_a_on, bank_b_on, driver_on, digital_out, led_fault});
    rd_seen <= reg_rd;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic look_out(input logic [4:0] e);
    @(posedge clk_sys);
    look <= 1'b1;
    out_q.push_back(e);
    @(posedge clk_sys);
    look <= 1'b0;
  endtask
  // move the contact, wait for it under a bound, let banks follow
  task automatic set_contact(input logic v);
    int n;
    @(posedge clk_sys);
    close_req <= v;
    for (n = 0; n < 20 && contact_closed !== v; n++) @(negedge clk_sys);
    if (n == 20) begin
      fails++;
      close_out();
    end
    repeat (3) @(posedge clk_sys);
  endtask
  // watchdog against any hang
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(beacon_pkg::REG_PATTERN, 16'h0000);
    rd(beacon_pkg::REG_INPUT, 16'h0000);
    rd(beacon_pkg::REG_DURATION, 16'h0014);
    rd(beacon_pkg::REG_STATUS, 16'h0000);
    look_out(5'h00);
    $display("test defaults done");
    for (i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      solar_volts <= lfsr[7:0];
      photo_night <= lfsr[8];
      repeat (2) @(posedge clk_sys);
      rd(beacon_pkg::REG_SOLAR, {8'h00, lfsr[7:0]});
      rd(beacon_pkg::REG_STATUS, {14'h0000, lfsr[8], 1'b0});
    end
    photo_night <= 1'b0;
    $display("test solar status done");
    dur_exp = 16'h0014;
    for (i = 0; i < 8; i++) begin
      wr(beacon_pkg::REG_DURATION, {4'h0, dur_v[i]});
      if (dur_ok[i]) dur_exp = {4'h0, dur_v[i]};
      rd(beacon_pkg::REG_DURATION, dur_exp);
    end
    lfsr = next_rand(lfsr);
    dur_exp = 16'(5 + lfsr[15:0] % 56);
    wr(beacon_pkg::REG_DURATION, dur_exp);
    rd(beacon_pkg::REG_DURATION, dur_exp);
    wr(beacon_pkg::REG_INPUT, 16'h0003);
    rd(beacon_pkg::REG_INPUT, 16'h0000);
    rd(4'h9, 16'h0000);
    $display("test registers done");
    wr(beacon_pkg::REG_INPUT, {14'h0000, beacon_pkg::IN_NORM_OPEN});
    wr(beacon_pkg::REG_DOUT, 16'h0001);
    for (i = 0; i < 8; i++) begin
      slow <= i[0];
      wr(beacon_pkg::REG_PATTERN, 16'(i));
      rd(beacon_pkg::REG_PATTERN, 16'(i));
      if (i != 2 && i != 3) begin
        set_contact(1'b1);
        look_out({pat_ab[i], |pat_ab[i], 2'b10});
        set_contact(1'b0);
        look_out(5'h00);
      end
    end
    $display("test patterns done");
    wr(beacon_pkg::REG_INPUT, {14'h0000, beacon_pkg::IN_NORM_CLOSED});
    repeat (3) @(posedge clk_sys);
    look_out(5'h1e);
    set_contact(1'b1);
    look_out(5'h00);
    wr(beacon_pkg::REG_INPUT, {14'h0000, beacon_pkg::IN_BUTTON});
    set_contact(1'b0);
    look_out(5'h00);
    set_contact(1'b1);
    set_contact(1'b0);
    look_out(5'h1e);
    rd(beacon_pkg::REG_STATUS, 16'h0010);
    battery_state <= beacon_pkg::BATT_LOW;
    repeat (3) @(posedge clk_sys);
    look_out(5'h1e);
    rd(beacon_pkg::REG_STATUS, 16'h0014);
    battery_state <= beacon_pkg::BATT_CUTOFF;
    repeat (2) @(posedge clk_sys);
    look_out(5'h00);
    battery_state <= beacon_pkg::BATT_GOOD;
    $display("test modes and battery done");
    wr(beacon_pkg::REG_INPUT, {14'h0000, beacon_pkg::IN_NORM_OPEN});
    set_contact(1'b1);
    led_short <= 1'b1;
    repeat (3) @(posedge clk_sys);
    look_out(5'h1f);
    led_short <= 1'b0;
    repeat (3) @(posedge clk_sys);
    look_out(5'h1f);
    set_contact(1'b0);
    set_contact(1'b1);
    look_out(5'h1e);
    bank_a_open <= 1'b1;
    bank_b_open <= 1'b1;
    repeat (3) @(posedge clk_sys);
    look_out(5'h1f);
    $display("test fault done");
    close_out();
  end
endmodule
